// ===== sdrc_cfg.svh
// constants of the sdram controller register interface
// How it works
// - mode zero: accesses run the normal activate, read, write, precharge flow
// - mode one: every access issues only a nop
// - mode two: every access issues precharge of all banks
// - mode three: load mode register with the access offset as value
// - mode four: every access issues an auto-refresh
// - mode five: extended load mode register with the access offset
// - mode six: memory enters deep power-down
// - 12-bit refresh count reloads a timer whose expiry pulses one refresh
// - no refresh at all until software writes the refresh count
// - configuration register resets to 852372C0
// - column field codes 0..3 give 8..11 column bits, reset 8
// - irq enable/disable write-only; mask and status read-only, reset zero
// - row field codes 0..2 give 11..13 row bits, 3 reserved
// - bank bit clear two banks, set four banks
// - cas field codes 1..3 give latency 1..3, 0 reserved
// - bus width bit clear 32 bits, set 16 bits
`ifndef SDRC_CFG_SVH
`define SDRC_CFG_SVH
`define SDRC_OFF_MODE 8'h00
`define SDRC_OFF_RFSH 8'h04
`define SDRC_OFF_CONF 8'h08
`define SDRC_OFF_HSPD 8'h0C
`define SDRC_OFF_LPWR 8'h10
`define SDRC_OFF_IEN 8'h14
`define SDRC_OFF_IDIS 8'h18
`define SDRC_OFF_IMSK 8'h1C
`define SDRC_OFF_ISTS 8'h20
`define SDRC_OFF_MDEV 8'h24
`define SDRC_CONF_RST 32'h852372C0
`define SDRC_COL_LSB 0
`define SDRC_ROW_LSB 2
`define SDRC_BANK_BIT 4
`define SDRC_CAS_LSB 5
`define SDRC_BW_BIT 7
`define SDRC_HSPD_MASK 32'h00000001
`define SDRC_LPWR_MASK 32'h00003FF3
`define SDRC_IRQ_MASK 32'h00000001
`define SDRC_MDEV_MASK 32'h00000013
`endif

// ===== sdrc_pkg.sv
// types of the sdram controller register interface
package sdrc_pkg;
  typedef enum logic [2:0] {
    SDRC_MD_NORMAL = 3'h0,
    SDRC_MD_NOP = 3'h1,
    SDRC_MD_PALL = 3'h2,
    SDRC_MD_LMR = 3'h3,
    SDRC_MD_AREF = 3'h4,
    SDRC_MD_ELMR = 3'h5,
    SDRC_MD_DPD = 3'h6,
    SDRC_MD_RSVD = 3'h7
  } sdrc_mode_t;
  typedef enum logic [2:0] {
    SDRC_CMD_NONE = 3'h0,
    SDRC_CMD_NOP = 3'h1,
    SDRC_CMD_PALL = 3'h2,
    SDRC_CMD_LMR = 3'h3,
    SDRC_CMD_AREF = 3'h4,
    SDRC_CMD_ELMR = 3'h5,
    SDRC_CMD_DPD = 3'h6,
    SDRC_CMD_NORMAL = 3'h7
  } sdrc_cmd_t;
  typedef struct packed {
    logic [3:0] col_bits;
    logic [3:0] row_bits;
    logic [2:0] bank_count;
    logic [1:0] cas_latency;
    logic [5:0] bus_width_select;
    logic [3:0] write_recovery_delay;
    logic [3:0] row_cycle_delay;
    logic [3:0] precharge_delay;
    logic [3:0] row_to_column_delay;
    logic [3:0] active_to_precharge_delay;
    logic [3:0] self_refresh_exit_delay;
  } sdrc_geom_t;
  typedef struct packed {
    logic valid;
    sdrc_cmd_t cmd;
    logic [27:0] mode_value;
  } sdrc_mem_cmd_t;
endpackage

// ===== sdrc_rfsh_timer.sv
// refresh interval timer
`timescale 1ns/1ns
module sdrc_rfsh_timer
  import sdrc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic load,
  input wire logic [11:0] count,
  output logic pulse
);
  logic armed_q, armed_d;
  logic [11:0] cnt_q, cnt_d;
  logic [11:0] reload_q, reload_d;
  logic pulse_q, pulse_d;

  always_comb begin
    armed_d = armed_q | load;
    reload_d = load ? count : reload_q;
    cnt_d = cnt_q;
    pulse_d = 1'b0;
    if (load) begin
      cnt_d = count;
    end else if (armed_q && reload_q != 12'h000) begin
      if (cnt_q == 12'h000) begin
        cnt_d = reload_q;
        pulse_d = 1'b1;
      end else begin
        cnt_d = cnt_q - 12'h001;
      end
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      armed_q <= 1'b0;
      cnt_q <= 12'h000;
      reload_q <= 12'h000;
      pulse_q <= 1'b0;
    end else begin
      armed_q <= armed_d;
      cnt_q <= cnt_d;
      reload_q <= reload_d;
      pulse_q <= pulse_d;
    end
  end

  assign pulse = pulse_q;
endmodule // sdrc_rfsh_timer

// ===== sdrc_regs.sv
// register file and command-mode selector of the sdram controller
`timescale 1ns/1ns
`include "sdrc_cfg.svh"
module sdrc_regs
  import sdrc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic [31:0] wb_dat_o,
  output logic wb_ack_o,
  input wire logic mem_acc_i,
  input wire logic [27:0] mem_offset_i,
  output sdrc_mem_cmd_t mem_cmd_o,
  output logic refresh_req_o,
  output logic deep_pd_o,
  output sdrc_geom_t geom_o,
  output logic [31:0] lpwr_o,
  output logic decode_cycle_o
);
  logic ack_q, ack_d;
  logic [31:0] rdat_q, rdat_d;
  logic [2:0] mode_q, mode_d;
  logic [11:0] rfsh_q, rfsh_d;
  logic [31:0] conf_q, conf_d;
  logic [31:0] hspd_q, hspd_d;
  logic [31:0] lpwr_q, lpwr_d;
  logic [31:0] imsk_q, imsk_d;
  logic [31:0] ists_q, ists_d;
  logic rfsh_load;
  sdrc_mem_cmd_t cmd_q, cmd_d;
  logic dpd_q, dpd_d;
  logic req;
  logic wr;

  // merge write data under byte enables
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] sel);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++) begin
      if (sel[i]) begin
        r[i*8 +: 8] = nw[i*8 +: 8];
      end
    end
    return r;
  endfunction

  assign req = wb_cyc_i & wb_stb_i & ~ack_q;
  assign wr = req & wb_we_i;

  always_comb begin
    ack_d = req;
    mode_d = mode_q;
    rfsh_d = rfsh_q;
    conf_d = conf_q;
    hspd_d = hspd_q;
    lpwr_d = lpwr_q;
    imsk_d = imsk_q;
    ists_d = ists_q;
    rfsh_load = 1'b0;
    rdat_d = 32'h00000000;
    if (wr) begin
      unique case (wb_adr_i)
        `SDRC_OFF_MODE: mode_d = 3'(merge({29'h0, mode_q}, wb_dat_i,
                                          wb_sel_i));
        `SDRC_OFF_RFSH: begin
          rfsh_d = 12'(merge({20'h0, rfsh_q}, wb_dat_i, wb_sel_i));
          rfsh_load = wb_sel_i[0] | wb_sel_i[1];
        end
        `SDRC_OFF_CONF: conf_d = merge(conf_q, wb_dat_i, wb_sel_i);
        `SDRC_OFF_HSPD: hspd_d = merge(hspd_q, wb_dat_i, wb_sel_i)
                                 & `SDRC_HSPD_MASK;
        `SDRC_OFF_LPWR: lpwr_d = merge(lpwr_q, wb_dat_i, wb_sel_i)
                                 & `SDRC_LPWR_MASK;
        `SDRC_OFF_IEN: imsk_d = imsk_q | (merge(32'h0, wb_dat_i, wb_sel_i)
                                          & `SDRC_IRQ_MASK);
        `SDRC_OFF_IDIS: imsk_d = imsk_q & ~merge(32'h0, wb_dat_i,
                                                 wb_sel_i);
        default: ;
      endcase
    end else if (req) begin
      unique case (wb_adr_i)
        `SDRC_OFF_MODE: rdat_d = {29'h0, mode_q};
        `SDRC_OFF_RFSH: rdat_d = {20'h0, rfsh_q};
        `SDRC_OFF_CONF: rdat_d = conf_q;
        `SDRC_OFF_HSPD: rdat_d = hspd_q;
        `SDRC_OFF_LPWR: rdat_d = lpwr_q;
        `SDRC_OFF_IMSK: rdat_d = imsk_q;
        `SDRC_OFF_ISTS: begin
          rdat_d = ists_q;
          ists_d = 32'h0;
        end
        `SDRC_OFF_MDEV: rdat_d = lpwr_q & `SDRC_MDEV_MASK & 32'h0;
        default: rdat_d = 32'h00000000;
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      ack_q <= 1'b0;
      rdat_q <= 32'h00000000;
      mode_q <= 3'h0;
      rfsh_q <= 12'h000;
      conf_q <= `SDRC_CONF_RST;
      hspd_q <= 32'h00000000;
      lpwr_q <= 32'h00000000;
      imsk_q <= 32'h00000000;
      ists_q <= 32'h00000000;
    end else begin
      ack_q <= ack_d;
      rdat_q <= rdat_d;
      mode_q <= mode_d;
      rfsh_q <= rfsh_d;
      conf_q <= conf_d;
      hspd_q <= hspd_d;
      lpwr_q <= lpwr_d;
      imsk_q <= imsk_d;
      ists_q <= ists_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  sdrc_rfsh_timer u_timer (
    .clk_sys(clk_sys),
    .rstn(rstn),
    .load(rfsh_load),
    .count(rfsh_d),
    .pulse(refresh_req_o)
  );

  // command selection per memory access
  always_comb begin
    cmd_d = '0;
    dpd_d = dpd_q;
    if (mem_acc_i) begin
      cmd_d.valid = 1'b1;
      cmd_d.mode_value = 28'h0;
      unique case (sdrc_mode_t'(mode_q))
        SDRC_MD_NOP: cmd_d.cmd = SDRC_CMD_NOP;
        SDRC_MD_PALL: cmd_d.cmd = SDRC_CMD_PALL;
        SDRC_MD_LMR: begin
          cmd_d.cmd = SDRC_CMD_LMR;
          cmd_d.mode_value = mem_offset_i;
        end
        SDRC_MD_AREF: cmd_d.cmd = SDRC_CMD_AREF;
        SDRC_MD_ELMR: begin
          cmd_d.cmd = SDRC_CMD_ELMR;
          cmd_d.mode_value = mem_offset_i;
        end
        SDRC_MD_DPD: begin
          cmd_d.cmd = SDRC_CMD_DPD;
          dpd_d = 1'b1;
        end
        SDRC_MD_NORMAL, SDRC_MD_RSVD: begin
          cmd_d.cmd = SDRC_CMD_NORMAL;
          dpd_d = 1'b0;
        end
      endcase
    end
  end

  always_ff @(posedge clk_sys or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= '0;
      dpd_q <= 1'b0;
    end else begin
      cmd_q <= cmd_d;
      dpd_q <= dpd_d;
    end
  end

  assign mem_cmd_o = cmd_q;
  assign deep_pd_o = dpd_q;
  assign lpwr_o = lpwr_q;
  assign decode_cycle_o = hspd_q[0];

  // decoded geometry; reserved row code 3 passes as 13 row bits, reserved cas code 0 as latency 2
  always_comb begin
    geom_o.col_bits = 4'(conf_q[`SDRC_COL_LSB +: 2]) + 4'h8;
    unique case (conf_q[`SDRC_ROW_LSB +: 2])
      2'h0: geom_o.row_bits = 4'hB;
      2'h1: geom_o.row_bits = 4'hC;
      default: geom_o.row_bits = 4'hD;
    endcase
    geom_o.bank_count = conf_q[`SDRC_BANK_BIT] ? 3'h4 : 3'h2;
    geom_o.cas_latency = (conf_q[`SDRC_CAS_LSB +: 2] == 2'h0) ? 2'h2
                         : conf_q[`SDRC_CAS_LSB +: 2];
    geom_o.bus_width_select = conf_q[`SDRC_BW_BIT] ? 6'h10 : 6'h20;
    geom_o.write_recovery_delay = conf_q[11:8];
    geom_o.row_cycle_delay = conf_q[15:12];
    geom_o.precharge_delay = conf_q[19:16];
    geom_o.row_to_column_delay = conf_q[23:20];
    geom_o.active_to_precharge_delay = conf_q[27:24];
    geom_o.self_refresh_exit_delay = conf_q[31:28];
  end
endmodule // sdrc_regs

// ===== sdrc_checker.sv
// port assertions of the sdram controller register interface
`timescale 1ns/1ns
module sdrc_checker
  import sdrc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic rstn,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [7:0] wb_adr_i,
  input wire logic [31:0] wb_dat_o,
  input wire logic wb_ack_o,
  input wire logic mem_acc_i,
  input wire logic refresh_req_o,
  input wire logic deep_pd_o,
  input wire logic [27:0] mem_offset_i,
  input wire sdrc_mem_cmd_t mem_cmd_o,
  input wire sdrc_geom_t geom_o
);
  default clocking cb @(posedge clk_sys);
  endclocking
  default disable iff (!rstn);
  sequence acc_s;
    mem_acc_i ##1 mem_cmd_o.valid;
  endsequence
  ack_resp_a: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o
    |=> wb_ack_o) else $error("request not acked");
  ack_pulse_a: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack longer than one cycle");
  cmd_valid_a: assert property (mem_acc_i |=> mem_cmd_o.valid)
    else $error("access without command");
  cmd_quiet_a: assert property (!mem_acc_i |=> !mem_cmd_o.valid)
    else $error("command without access");
  mode_value_a: assert property (acc_s ##0 mem_cmd_o.cmd inside
    {SDRC_CMD_LMR, SDRC_CMD_ELMR} |-> mem_cmd_o.mode_value ==
    $past(mem_offset_i)) else $error("mode value not offset");
  pd_enter_a: assert property (mem_cmd_o.valid &&
    mem_cmd_o.cmd == SDRC_CMD_DPD |-> ##[0:1] deep_pd_o)
    else $error("deep power-down not entered");
  pd_leave_a: assert property (mem_cmd_o.valid &&
    mem_cmd_o.cmd == SDRC_CMD_NORMAL |-> !deep_pd_o)
    else $error("deep power-down not left");
  rfsh_pulse_a: assert property (refresh_req_o |=> !refresh_req_o)
    else $error("refresh pulse too long");
  rsvd_zero_a: assert property (wb_ack_o && !wb_we_i &&
    (wb_adr_i >= 8'h28 || wb_adr_i inside {8'h14, 8'h18})
    |-> wb_dat_o == 32'h0) else $error("reserved read not zero");
  geom_range_a: assert property (geom_o.col_bits inside
    {[4'h8:4'hB]} && geom_o.row_bits inside {[4'hB:4'hD]})
    else $error("geometry out of range");
endmodule // sdrc_checker

// ===== sdrc_mem_model.sv
// behavioural sdram side: counts refresh bursts and their spacing
`timescale 1ns/1ns
module sdrc_mem_model
  import sdrc_pkg::*;
(
  input wire logic clk_sys,
  input wire logic refresh_req_o,
  output int rf_cnt = 0,
  output int rf_gap = 0
);
  int since = 0;
  always @(posedge clk_sys) begin
    since <= since + 1;
    if (refresh_req_o) begin
      rf_cnt <= rf_cnt + 1;
      rf_gap <= since;
      since <= 1;
    end
  end
endmodule // sdrc_mem_model

// ===== tb_top.sv
// self-checking bench of the sdram controller register interface
`timescale 1ns/1ns
module tb_top
  import sdrc_pkg::*;
;
  logic clk_sys = 0, rstn = 0, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic mem_acc_i = 0, wb_ack_o, refresh_req_o, deep_pd_o, decode_cycle_o;
  logic [7:0] wb_adr_i = 8'h00;
  logic [3:0] wb_sel_i = 4'hF;
  logic [31:0] wb_dat_i = 32'h0, wb_dat_o, lpwr_o, rd;
  logic [27:0] mem_offset_i = 28'h0;
  sdrc_mem_cmd_t mem_cmd_o;
  sdrc_geom_t geom_o;
  int rf_cnt, rf_gap, err_count = 0, tests_run = 0;
  always #10 clk_sys = ~clk_sys;
  sdrc_regs u_sdrc_regs (
    .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
    .wb_sel_i(wb_sel_i), .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o),
    .wb_ack_o(wb_ack_o), .mem_acc_i(mem_acc_i),
    .mem_offset_i(mem_offset_i), .mem_cmd_o(mem_cmd_o),
    .refresh_req_o(refresh_req_o), .deep_pd_o(deep_pd_o),
    .geom_o(geom_o), .lpwr_o(lpwr_o), .decode_cycle_o(decode_cycle_o)
  );
  sdrc_mem_model u_sdrc_mem_model (
    .clk_sys(clk_sys), .refresh_req_o(refresh_req_o),
    .rf_cnt(rf_cnt), .rf_gap(rf_gap)
  );
  task automatic check(string what, logic [31:0] seen, exp);
    tests_run++;
    if (seen !== exp) begin
      err_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task automatic final_report();
    $display("checks %0d mismatches %0d", tests_run, err_count);
    if (err_count == 0 && tests_run > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  task automatic wb(logic we, logic [7:0] a, logic [31:0] d);
    int n;
    @(posedge clk_sys);
    {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'h3, we};
    {wb_adr_i, wb_dat_i} <= {a, d};
    n = 0;
    do begin
      @(posedge clk_sys);
      n++;
    end while (wb_ack_o !== 1'b1 && n < 20);
    if (wb_ack_o !== 1'b1) begin
      err_count++;
      final_report();
    end else begin
      rd = wb_dat_o;
      {wb_cyc_i, wb_stb_i} <= 2'h0;
    end
  endtask
  // command is registered, so look at it mid-cycle after the taking edge
  task automatic acc(logic [27:0] off);
    @(posedge clk_sys);
    {mem_acc_i, mem_offset_i} <= {1'b1, off};
    @(posedge clk_sys);
    mem_acc_i <= 1'b0;
    @(negedge clk_sys);
  endtask
  function automatic logic [31:0] gv();
    return {13'h0, geom_o.col_bits, geom_o.row_bits, geom_o.bank_count,
      geom_o.cas_latency, geom_o.bus_width_select};
  endfunction
  task automatic t_reset();
    logic [7:0] zr[5] = '{8'h00, 8'h04, 8'h1C, 8'h20, 8'h30};
    wb(1'b0, 8'h08, 32'h0);
    check("conf", rd, 32'h852372C0);
    check("geom", gv(), {13'h0, 4'h8, 4'hB, 3'h2, 2'h2, 6'h10});
    foreach (zr[i]) begin
      wb(1'b0, zr[i], 32'h0);
      check("zero", rd, 32'h0);
    end
    check("early rfsh", rf_cnt, 0);
    $display("reset test done");
  endtask
  task automatic t_rfsh();
    int n;
    wb(1'b1, 8'h04, 32'h5);
    repeat (30) @(posedge clk_sys);
    check("gap", rf_gap, 6);
    check("bursts", rf_cnt > 3, 1);
    wb(1'b1, 8'h04, 32'h0);
    n = rf_cnt;
    repeat (20) @(posedge clk_sys);
    check("stopped", rf_cnt, n);
    $display("refresh test done");
  endtask
  task automatic t_regs();
    wb(1'b1, 8'h14, 32'h1);
    wb(1'b0, 8'h14, 32'h0);
    check("ien", rd, 32'h0);
    wb(1'b0, 8'h1C, 32'h0);
    check("mask set", rd, 32'h1);
    wb(1'b1, 8'h18, 32'h1);
    wb(1'b0, 8'h18, 32'h0);
    check("idis", rd, 32'h0);
    wb(1'b0, 8'h1C, 32'h0);
    check("mask clr", rd, 32'h0);
    wb(1'b1, 8'h10, 32'hFFFFFFFF);
    check("lpwr out", lpwr_o, 32'h00003FF3);
    wb(1'b1, 8'h0C, 32'h1);
    check("decode", {31'h0, decode_cycle_o}, 32'h1);
    wb(1'b0, 8'h24, 32'h0);
    check("mdev", rd, 32'h0);
    wb(1'b1, 8'h00, 32'hFFFFFFFE);
    wb(1'b0, 8'h00, 32'h0);
    check("mode rw", rd, 32'h6);
    wb(1'b1, 8'h20, 32'hFFFFFFFF);
    wb(1'b1, 8'h30, 32'h0);
    wb(1'b0, 8'h20, 32'h0);
    check("status", rd, 32'h0);
    wb(1'b1, 8'h08, 32'h8523723B);
    wb(1'b0, 8'h08, 32'h0);
    check("conf rw", rd, 32'h8523723B);
    check("geom", gv(), {13'h0, 4'hB, 4'hD, 3'h4, 2'h1, 6'h20});
    $display("register test done");
  endtask
  task automatic t_modes();
    sdrc_cmd_t exp;
    for (int m = 0; m < 8; m++) begin
      wb(1'b1, 8'h00, m);
      acc(28'h123 + 28'(m));
      exp = (m == 0 || m == 7) ? SDRC_CMD_NORMAL : sdrc_cmd_t'(m);
      check("cmd", mem_cmd_o.cmd, exp);
      if (m == 3 || m == 5)
        check("value", mem_cmd_o.mode_value, 28'h123 + 28'(m));
      if (m == 6)
        check("pd on", deep_pd_o, 1'b1);
    end
    check("pd off", deep_pd_o, 1'b0);
    $display("mode test done");
  endtask
  // reset again while the timer runs: nothing may survive it
  task automatic t_rerun();
    int n;
    wb(1'b1, 8'h04, 32'h3);
    wb(1'b1, 8'h08, 32'h0);
    @(posedge clk_sys);
    rstn <= 1'b0;
    repeat (2) @(posedge clk_sys);
    rstn <= 1'b1;
    n = rf_cnt;
    wb(1'b0, 8'h08, 32'h0);
    check("conf again", rd, 32'h852372C0);
    wb(1'b0, 8'h04, 32'h0);
    check("rfsh again", rd, 32'h0);
    repeat (20) @(posedge clk_sys);
    check("quiet again", rf_cnt, n);
    $display("second reset test done");
  endtask
  initial begin
    repeat (4) @(posedge clk_sys);
    rstn <= 1'b1;
    t_reset();
    t_rfsh();
    t_regs();
    t_modes();
    t_rerun();
    final_report();
  end
endmodule // tb_top
bind sdrc_regs sdrc_checker u_sdrc_checker (
  .clk_sys(clk_sys), .rstn(rstn), .wb_cyc_i(wb_cyc_i),
  .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i),
  .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o), .mem_acc_i(mem_acc_i),
  .refresh_req_o(refresh_req_o), .deep_pd_o(deep_pd_o),
  .mem_offset_i(mem_offset_i), .mem_cmd_o(mem_cmd_o), .geom_o(geom_o)
);
